// ---- core/bootstrap_symbol_gen.v ----
// Bootstrap symbol generator: PN and ZC mapping, direct IFFT, cyclic shift
`timescale 1ns/10ps
`default_nettype none
`include "bootstrap_defs.vh"

// Function
// R1 - PN generator is a sixteen-stage linear feedback shift register
// R2 - Polynomial plus initial state form the seed naming the minor version
// R3 - Seed loaded into the register before each new bootstrap's first symbol
// R4 - Register keeps running across symbols, never reseeded inside a bootstrap
// R5 - First PN bit is the register output before any shift
// R6 - Each further PN bit comes from one right shift
// R7 - Feedback polynomial is x^16 + x^15 + x^14 + x + 1
// R8 - ZC value on the DC subcarrier is forced to zero
// R9 - PN values below DC are mirrored onto the subcarriers above DC
// R10 - ZC index k+H times chip (n+1)H+k or (n+1)H-k; ZC same each symbol
// R11 - Chip equals one minus twice the PN bit
// R12 - Every subcarrier of the last symbol is negated
// R13 - 2048-point inverse transform scaled by one over sqrt(N_ZC-1)
// R14 - Signaling only by cyclic shifts 0 to 2047, at most 11 bits
// R15 - Valid signaling bits are 0 or 1, unused positions held at zero
// R16 - Relative shift bits: prefix XOR above 10-N, one at 10-N, zero below
// R17 - First symbol has cyclic shift zero
// R18 - Absolute shift is previous absolute plus relative, modulo 2048
// R19 - Output sample t is transform sample (t plus shift) modulo 2048
// R20 - Receivers ignore signaling bits they are not provisioned for
// R21 - ZC length 1499 with root naming the major version
// R22 - ZC value k is exp(-j*pi*q*k*(k+1)/1499)
// R23 - 2048 shifted samples streamed in order with valid and symbol markers
// R24 - Controller supplies seed, root, count and signaling before start
module bootstrap_symbol_gen (
  input  wire                 clk_sys_i,     // System clock, 100 MHz
  input  wire                 rst_n_i,       // Asynchronous reset, active low
  input  wire                 ce_i,          // Clock enable, freezes all state
  input  wire                 start_i,       // Start a bootstrap, taken while ready_o
  input  wire [`SEED_W-1:0]   pn_seed_i,     // PN register initial state
  input  wire [`ROOT_W-1:0]   zc_root_i,     // ZC root q, 1..1498
  input  wire [`CNT_W-1:0]    sym_count_i,   // Symbols in the bootstrap, 1..64
  input  wire                 sig_wr_i,      // Signaling table write strobe
  input  wire [`SYM_AW-1:0]   sig_sym_i,     // Symbol index of the write
  input  wire [`NB_W-1:0]     sig_nb_i,      // Valid signaling bit count, 0..11
  input  wire [`SHIFT_W-1:0]  sig_bits_i,    // Signaling bits, bit 0 first
  input  wire                 samp_ready_i,  // Downstream takes a sample
  output wire                 samp_valid_o,  // Sample valid
  output wire [`SAMP_W-1:0]   samp_re_o,     // Sample real part, Q8.8
  output wire [`SAMP_W-1:0]   samp_im_o,     // Sample imaginary part, Q8.8
  output wire                 samp_first_o,  // First sample of a symbol
  output wire                 samp_last_o,   // Last sample of a symbol
  output wire                 sym_first_o,   // Sample belongs to the first symbol
  output wire                 sym_last_o,    // Sample belongs to the last symbol
  output reg                  ready_o        // Idle and able to take start_i
);

  localparam [2:0] ST_COS  = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ZC   = 3'h2;
  localparam [2:0] ST_PN   = 3'h3;
  localparam [2:0] ST_MAC  = 3'h4;
  localparam [2:0] ST_OUT  = 3'h5;

  reg  [`SAMP_W-1:0]          cos_mem [0:`N_FFT-1];
  reg  [`SAMP_W-1:0]          zre_mem [0:`N_HALF-1];
  reg  [`SAMP_W-1:0]          zim_mem [0:`N_HALF-1];
  reg                         pn_mem  [0:`N_HALF-1];
  reg  [`NB_W+`SHIFT_W-1:0]   sig_mem [0:`SYM_MAX-1];

  reg  [2:0]                  state_reg;
  reg  [`SEED_W-1:0]          lfsr_reg;
  reg  [11:0]                 q2_reg;
  reg  [`CNT_W-1:0]           nsym_reg;
  reg  [`SYM_AW-1:0]          sym_reg;
  reg  [`SHIFT_W-1:0]         idx_reg;
  reg  [`SHIFT_W-1:0]         t_reg;
  reg  [`SHIFT_W-1:0]         abs_reg;
  reg  [`SHIFT_W-1:0]         ph_reg;
  reg  [11:0]                 zr_reg;
  reg  [11:0]                 zd_reg;
  reg  [4:0]                  cit_reg;
  reg  signed [`CORDIC_W-1:0] cx_reg;
  reg  signed [`CORDIC_W-1:0] cy_reg;
  reg  [15:0]                 cz_reg;
  reg  signed [41:0]          acc_re_reg;
  reg  signed [41:0]          acc_im_reg;

  wire                        c_done;
  wire [3:0]                  c_shift;
  wire signed [`CORDIC_W-1:0] cx_sh;
  wire signed [`CORDIC_W-1:0] cy_sh;
  wire [15:0]                 c_atan;
  wire [26:0]                 zc_prod;
  wire [15:0]                 c_ang;
  wire                        c_flip;
  wire [9:0]                  kk;
  wire [9:0]                  rev_idx;
  wire                        last_sym;
  wire                        neg;
  wire signed [31:0]          prod_re;
  wire signed [31:0]          prod_im;
  wire signed [41:0]          term_re;
  wire signed [41:0]          term_im;
  wire signed [43:0]          sc_re;
  wire signed [43:0]          sc_im;
  wire [`NB_W+`SHIFT_W-1:0]   sig_word;
  wire [`NB_W-1:0]            sig_nb;
  wire [`SHIFT_W-1:0]         sig_bits;
  wire [`SHIFT_W-1:0]         bm;
  wire [`SHIFT_W-1:0]         rel_shift;
  wire [`SHIFT_W-1:0]         abs_next;
  wire [`SHIFT_W-1:0]         t_inc;
  wire                        buf_in_valid;
  wire                        buf_in_ready;
  wire [`BUF_W-1:0]           buf_in_data;
  wire [`BUF_W-1:0]           buf_out_data;

  // Arc tangent of 2^-i in units of 1/65536 turn
  function [15:0] atan_turn;
    input [3:0] i;
    begin
      case (i)
        4'h0:    atan_turn = 16'h2000;
        4'h1:    atan_turn = 16'h12E4;
        4'h2:    atan_turn = 16'h09FB;
        4'h3:    atan_turn = 16'h0511;
        4'h4:    atan_turn = 16'h028B;
        4'h5:    atan_turn = 16'h0146;
        4'h6:    atan_turn = 16'h00A3;
        4'h7:    atan_turn = 16'h0051;
        4'h8:    atan_turn = 16'h0029;
        4'h9:    atan_turn = 16'h0014;
        4'hA:    atan_turn = 16'h000A;
        4'hB:    atan_turn = 16'h0005;
        4'hC:    atan_turn = 16'h0003;
        4'hD:    atan_turn = 16'h0001;
        default: atan_turn = 16'h0000;
      endcase
    end
  endfunction

  // Sum of two residues modulo 2*N_ZC
  function [11:0] mod_add;
    input [11:0] a;
    input [11:0] b;
    reg   [12:0] s;
    reg   [12:0] d;
    begin
      s = {1'b0, a} + {1'b0, b};
      d = s - `ZC_MOD;
      mod_add = (s >= `ZC_MOD) ? d[11:0] : s[11:0];
    end
  endfunction

  // Shared iterative CORDIC: cosine table at power-up, ZC values per bootstrap
  assign c_done  = (cit_reg == `CORDIC_DONE);
  assign c_shift = cit_reg[3:0] - 4'h1;
  assign cx_sh   = cx_reg >>> c_shift;
  assign cy_sh   = cy_reg >>> c_shift;
  assign c_atan  = atan_turn(c_shift);
  // R22 phase q*k*(k+1)/(2*1499) as a turn fraction, rotated negative
  assign zc_prod = zr_reg * `ZC_TURN_MUL;
  assign c_ang   = (state_reg == ST_COS) ? {idx_reg, 5'h00} : (16'h0000 - zc_prod[25:10]);
  assign c_flip  = c_ang[15] ^ c_ang[14];

  // Entry kk holds subcarrier +(kk+1) and, mirrored, -(kk+1)
  assign kk       = idx_reg[9:0];
  assign rev_idx  = `HALF_LAST - idx_reg[9:0];
  assign last_sym = ({1'b0, sym_reg} == nsym_reg - 7'h01);
  // R11 chip sign from PN bit
  // R12 last symbol inverted
  assign neg      = pn_mem[kk] ^ last_sym;
  assign prod_re  = $signed(zre_mem[kk]) * $signed(cos_mem[ph_reg]);
  assign prod_im  = $signed(zim_mem[kk]) * $signed(cos_mem[ph_reg]);
  assign term_re  = {{10{prod_re[31]}}, prod_re};
  assign term_im  = {{10{prod_im[31]}}, prod_im};
  // R13 scale by 2/sqrt(1498): mirrored pair counted once
  assign sc_re    = $signed(acc_re_reg[41:15]) * $signed(`OUT_SCALE);
  assign sc_im    = $signed(acc_im_reg[41:15]) * $signed(`OUT_SCALE);

  assign sig_word = sig_mem[sym_reg];
  assign sig_nb   = sig_word[`NB_W+`SHIFT_W-1:`SHIFT_W];
  assign sig_bits = sig_word[`SHIFT_W-1:0];

  // R16 Gray-coded relative shift per bit
  genvar gi;
  generate
    for (gi = 0; gi < `SHIFT_W; gi = gi + 1) begin : g_rel
      localparam [4:0] POS = gi;
      wire [4:0] lvl;
      assign lvl = {1'b0, sig_nb} + POS;
      // R15 unused bits zero
      assign bm[gi] = sig_bits[gi] & (POS < {1'b0, sig_nb});
      assign rel_shift[gi] = (lvl > `SIG_TOP) ? ^bm[`SHIFT_W-1-gi:0] : (lvl == `SIG_TOP);
    end
  endgenerate

  // R17 symbol zero unshifted
  // R18 accumulate modulo 2048 by 11-bit wrap
  assign abs_next = (sym_reg == {`SYM_AW{1'b0}}) ? {`SHIFT_W{1'b0}} : abs_reg + rel_shift;
  assign t_inc    = t_reg + 11'h001;

  // R23 sample word with position markers
  assign buf_in_valid = (state_reg == ST_OUT);
  assign buf_in_data  = {sc_re[38:23], sc_im[38:23], (t_reg == 11'h000), (t_reg == `FFT_LAST),
                         (sym_reg == {`SYM_AW{1'b0}}), last_sym};

  // R24 table filled by the controller before start
  always @(posedge clk_sys_i) begin
    if (ce_i && sig_wr_i) begin
      sig_mem[sig_sym_i] <= {sig_nb_i, sig_bits_i};
    end
  end

  always @(posedge clk_sys_i) begin
    if (ce_i && c_done && state_reg == ST_COS) begin
      cos_mem[idx_reg] <= cx_reg[15:0];
    end
  end

  // R8 DC entry never stored: index N_H is skipped, so DC carries zero
  // R10 ZC index j stored at subcarrier N_H-j, same for every symbol
  always @(posedge clk_sys_i) begin
    if (ce_i && c_done && state_reg == ST_ZC) begin
      zre_mem[rev_idx] <= cx_reg[15:0];
      zim_mem[rev_idx] <= cy_reg[15:0];
    end
  end

  // R5 bit taken before the shift
  // R9 chip j serves subcarriers -(N_H-j) and +(N_H-j)
  always @(posedge clk_sys_i) begin
    if (ce_i && state_reg == ST_PN) begin
      pn_mem[rev_idx] <= lfsr_reg[0];
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg  <= ST_COS;
      ready_o    <= 1'b0;
      lfsr_reg   <= {`SEED_W{1'b0}};
      q2_reg     <= 12'h000;
      nsym_reg   <= 7'h01;
      sym_reg    <= {`SYM_AW{1'b0}};
      idx_reg    <= {`SHIFT_W{1'b0}};
      t_reg      <= {`SHIFT_W{1'b0}};
      abs_reg    <= {`SHIFT_W{1'b0}};
      ph_reg     <= {`SHIFT_W{1'b0}};
      zr_reg     <= 12'h000;
      zd_reg     <= 12'h000;
      cit_reg    <= 5'h00;
      cx_reg     <= {`CORDIC_W{1'b0}};
      cy_reg     <= {`CORDIC_W{1'b0}};
      cz_reg     <= 16'h0000;
      acc_re_reg <= 42'h000_0000_0000;
      acc_im_reg <= 42'h000_0000_0000;
    end else if (ce_i) begin
      if (state_reg == ST_COS || state_reg == ST_ZC) begin
        if (cit_reg == 5'h00) begin
          cx_reg  <= c_flip ? (18'h00000 - `CORDIC_GAIN) : `CORDIC_GAIN;
          cy_reg  <= {`CORDIC_W{1'b0}};
          cz_reg  <= c_flip ? (c_ang - `HALF_TURN) : c_ang;
          cit_reg <= 5'h01;
        end else if (!c_done) begin
          if (!cz_reg[15]) begin
            cx_reg <= cx_reg - cy_sh;
            cy_reg <= cy_reg + cx_sh;
            cz_reg <= cz_reg - c_atan;
          end else begin
            cx_reg <= cx_reg + cy_sh;
            cy_reg <= cy_reg - cx_sh;
            cz_reg <= cz_reg + c_atan;
          end
          cit_reg <= cit_reg + 5'h01;
        end else begin
          cit_reg <= 5'h00;
        end
      end
      case (state_reg)
        ST_COS: begin
          if (c_done) begin
            idx_reg <= idx_reg + 11'h001;
            if (idx_reg == `FFT_LAST) begin
              state_reg <= ST_IDLE;
              ready_o   <= 1'b1;
            end
          end
        end
        ST_IDLE: begin
          if (start_i) begin
            // R2 seed and root name the versions
            // R3 seed loaded per bootstrap
            // R21 root selects the ZC sequence
            lfsr_reg  <= pn_seed_i;
            q2_reg    <= mod_add(12'h000, {zc_root_i, 1'b0});
            zd_reg    <= mod_add(12'h000, {zc_root_i, 1'b0});
            nsym_reg  <= (sym_count_i == 7'h00) ? 7'h01 : sym_count_i;
            sym_reg   <= {`SYM_AW{1'b0}};
            idx_reg   <= {`SHIFT_W{1'b0}};
            zr_reg    <= 12'h000;
            abs_reg   <= {`SHIFT_W{1'b0}};
            ready_o   <= 1'b0;
            state_reg <= ST_ZC;
          end
        end
        ST_ZC: begin
          if (c_done) begin
            zr_reg <= mod_add(zr_reg, zd_reg);
            zd_reg <= mod_add(zd_reg, q2_reg);
            if (idx_reg[9:0] == `HALF_LAST) begin
              idx_reg   <= {`SHIFT_W{1'b0}};
              state_reg <= ST_PN;
            end else begin
              idx_reg <= idx_reg + 11'h001;
            end
          end
        end
        ST_PN: begin
          // R1 sixteen-stage register
          // R6 one bit per right shift
          // R7 feedback taps
          lfsr_reg <= {^(lfsr_reg & `PN_FB_MASK), lfsr_reg[`SEED_W-1:1]};
          if (idx_reg[9:0] == `HALF_LAST) begin
            // R14 signaling carried only by the shift
            abs_reg    <= abs_next;
            ph_reg     <= abs_next;
            t_reg      <= {`SHIFT_W{1'b0}};
            idx_reg    <= {`SHIFT_W{1'b0}};
            acc_re_reg <= 42'h000_0000_0000;
            acc_im_reg <= 42'h000_0000_0000;
            state_reg  <= ST_MAC;
          end else begin
            idx_reg <= idx_reg + 11'h001;
          end
        end
        ST_MAC: begin
          // R13 direct inverse transform over the mirrored subcarriers
          // R19 phase steps by t plus shift, wrapping modulo 2048
          acc_re_reg <= neg ? acc_re_reg - term_re : acc_re_reg + term_re;
          acc_im_reg <= neg ? acc_im_reg - term_im : acc_im_reg + term_im;
          ph_reg     <= ph_reg + t_reg + abs_reg;
          if (idx_reg[9:0] == `HALF_LAST) begin
            state_reg <= ST_OUT;
          end else begin
            idx_reg <= idx_reg + 11'h001;
          end
        end
        ST_OUT: begin
          if (buf_in_ready) begin
            idx_reg    <= {`SHIFT_W{1'b0}};
            acc_re_reg <= 42'h000_0000_0000;
            acc_im_reg <= 42'h000_0000_0000;
            if (t_reg == `FFT_LAST) begin
              if (last_sym) begin
                state_reg <= ST_IDLE;
                ready_o   <= 1'b1;
              end else begin
                // R4 register continues into the next symbol
                sym_reg   <= sym_reg + 6'h01;
                state_reg <= ST_PN;
              end
            end else begin
              t_reg     <= t_inc;
              ph_reg    <= t_inc + abs_reg;
              state_reg <= ST_MAC;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          ready_o   <= 1'b1;
        end
      endcase
    end
  end

  // R23 stall-safe output stream
  two_entry_buffer #(
    .W (`BUF_W)
  ) u_out_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (buf_in_valid),
    .in_data_i   (buf_in_data),
    .in_ready_o  (buf_in_ready),
    .out_valid_o (samp_valid_o),
    .out_data_o  (buf_out_data),
    .out_ready_i (samp_ready_i)
  );

  assign samp_re_o    = buf_out_data[35:20];
  assign samp_im_o    = buf_out_data[19:4];
  assign samp_first_o = buf_out_data[3];
  assign samp_last_o  = buf_out_data[2];
  assign sym_first_o  = buf_out_data[1];
  assign sym_last_o   = buf_out_data[0];

endmodule // bootstrap_symbol_gen

`default_nettype wire

// ---- core/two_entry_buffer.v ----
// Two-entry registered buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module two_entry_buffer #(
  parameter W = 36                      // Word width
) (
  input  wire         clk_sys_i,        // System clock
  input  wire         rst_n_i,          // Asynchronous reset, active low
  input  wire         ce_i,             // Clock enable
  input  wire         in_valid_i,       // Source word valid
  input  wire [W-1:0] in_data_i,        // Source word
  output reg          in_ready_o,       // Buffer can take a word
  output reg          out_valid_o,      // Head word valid
  output reg  [W-1:0] out_data_o,       // Head word
  input  wire         out_ready_i       // Sink takes the head word
);

  reg  [W-1:0] skid_reg;
  wire         push;
  wire         pop;

  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  // Second entry catches a word while the sink stalls; ready drops when both are full
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
      out_data_o  <= {W{1'b0}};
      skid_reg    <= {W{1'b0}};
    end else if (ce_i) begin
      if (!in_ready_o && pop) begin
        out_data_o <= skid_reg;
        in_ready_o <= 1'b1;
      end else if (push) begin
        if (out_valid_o && !pop) begin
          skid_reg   <= in_data_i;
          in_ready_o <= 1'b0;
        end else begin
          out_data_o  <= in_data_i;
          out_valid_o <= 1'b1;
        end
      end else if (pop) begin
        out_valid_o <= 1'b0;
      end
    end
  end

endmodule // two_entry_buffer

`default_nettype wire

// ---- include/bootstrap_defs.vh ----
// Constants shared by the bootstrap symbol generator and its output buffer
`ifndef BOOTSTRAP_DEFS_VH
`define BOOTSTRAP_DEFS_VH

// Transform and sequence sizes
`define N_FFT        2048
`define FFT_LAST     11'h7FF
`define N_HALF       749
`define HALF_LAST    10'h2EC
`define SHIFT_W      11
`define SIG_TOP      5'h0A
`define NB_W         4

// Pseudo-noise register: width and feedback taps for x^16+x^15+x^14+x+1
`define SEED_W       16
`define PN_FB_MASK   16'hC003

// Zadoff-Chu phase: q*k*(k+1) is kept modulo 2*N_ZC
`define ZC_MOD       13'h0BB6
`define ZC_TURN_MUL  15'h5771
`define ROOT_W       11

// CORDIC: 18-bit datapath, 14 iterations, gain-corrected start value
`define CORDIC_W     18
`define CORDIC_ITER  5'h0E
`define CORDIC_DONE  5'h0F
`define CORDIC_GAIN  18'h04DB2
`define HALF_TURN    16'h8000

// Output: Q8.8 samples, scale 2/sqrt(N_ZC-1) in Q16
`define SAMP_W       16
`define OUT_SCALE    17'h00D3A

// Symbol table
`define SYM_MAX      64
`define SYM_AW       6
`define CNT_W        7

// Buffered word: {re, im, first sample, last sample, first symbol, last symbol}
`define BUF_W        36

`endif

// ---- verification/bootstrap_checker.sv ----
// Port assertions for the bootstrap symbol generator
`timescale 1ns/10ps
`default_nettype none
module bootstrap_checker (
  input wire logic        clk_sys_i,    // Clock
  input wire logic        rst_n_i,      // Reset, active low
  input wire logic        ce_i,         // Clock enable
  input wire logic        start_i,      // Start request
  input wire logic        samp_ready_i, // Sink ready
  input wire logic        samp_valid_o, // Sample valid
  input wire logic [15:0] samp_re_o,    // Real part
  input wire logic [15:0] samp_im_o,    // Imaginary part
  input wire logic        samp_first_o, // First sample
  input wire logic        samp_last_o,  // Last sample
  input wire logic        sym_last_o,   // Last symbol
  input wire logic        ready_o       // Idle
);
  wire       take = samp_valid_o && samp_ready_i && ce_i;
  reg [10:0] t_reg;
  reg        started_reg;
  reg        lastsym_reg;
  // Sample index within a symbol, wraps after 2048
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_reg <= 11'h000;
      started_reg <= 1'b0;
      lastsym_reg <= 1'b0;
    end else begin
      if (take)
        t_reg <= t_reg + 11'h001;
      if (take && samp_first_o)
        lastsym_reg <= sym_last_o;
      if (ready_o && start_i && ce_i)
        started_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  AST_VALID_HOLD: assert property (samp_valid_o && !take |=> samp_valid_o)
    else $error("valid dropped before the word was taken");
  AST_DATA_HOLD: assert property (samp_valid_o && !take |=>
    $stable({samp_re_o, samp_im_o, samp_first_o, samp_last_o, sym_last_o}))
    else $error("sample word changed while stalled");
  AST_START_BUSY: assert property (ready_o && start_i && ce_i |=> !ready_o)
    else $error("ready stayed high after start");
  AST_FIRST_MARK: assert property (samp_valid_o |-> samp_first_o == (t_reg == 11'h000))
    else $error("first sample marker misplaced");
  AST_LAST_MARK: assert property (samp_valid_o |-> samp_last_o == (t_reg == 11'h7FF))
    else $error("last sample marker misplaced");
  AST_SYM_STEADY: assert property (samp_valid_o && !samp_first_o |->
    sym_last_o == lastsym_reg)
    else $error("last symbol marker changed inside a symbol");
  AST_CE_FREEZE: assert property (!ce_i |=>
    $stable({samp_valid_o, ready_o, samp_re_o, samp_im_o}))
    else $error("outputs moved with clock enable low");
  AST_QUIET_IDLE: assert property (!started_reg |-> !samp_valid_o)
    else $error("sample offered before any start");
  COV_START: cover property (ready_o && start_i && ce_i);
  COV_STALL: cover property ((samp_valid_o && !samp_ready_i) [*4]);
  COV_FIRST: cover property (take && samp_first_o);
endmodule // bootstrap_checker
`default_nettype wire

// ---- verification/sample_sink.sv ----
// Downstream sample sink with random and forced stalls
`timescale 1ns/10ps
`default_nettype none
module sample_sink (
  input  wire logic clk_sys_i,    // Clock
  input  wire logic stall_i,      // Hold ready low
  output var  logic samp_ready_o  // Takes a sample
);
  integer seed = 32'hed83;
  initial samp_ready_o = 1'b0;
  always @(negedge clk_sys_i)
    samp_ready_o <= !stall_i && ($random(seed) % 3 != 0);
endmodule // sample_sink
`default_nettype wire

// ---- verification/tb_bootstrap_symbol_gen.sv ----
// Self-checking bench for the bootstrap symbol generator
`timescale 1ns/10ps
`default_nettype none
module tb_bootstrap_symbol_gen;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        start_i = 1'b0;
  logic [15:0] pn_seed_i = 16'h0000;
  logic [10:0] zc_root_i = 11'h001;
  logic [6:0]  sym_count_i = 7'h01;
  logic        sig_wr_i = 1'b0;
  logic [5:0]  sig_sym_i = 6'h00;
  logic [3:0]  sig_nb_i = 4'h0;
  logic [10:0] sig_bits_i = 11'h000;
  logic        stall = 1'b1;
  wire         samp_ready_i, samp_valid_o, samp_first_o, samp_last_o;
  wire         sym_first_o, sym_last_o, ready_o;
  wire [15:0]  samp_re_o, samp_im_o;
  logic [35:0] got_q[$];
  int          miscompares = 0;
  int          num_checks = 0;
  int          seed = 32'hed83;
  real         er[0:2], ei[0:2];
  event        hang;
  always #5 clk_sys_i = ~clk_sys_i;
  bootstrap_symbol_gen i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .start_i(start_i), .pn_seed_i(pn_seed_i), .zc_root_i(zc_root_i),
    .sym_count_i(sym_count_i), .sig_wr_i(sig_wr_i), .sig_sym_i(sig_sym_i),
    .sig_nb_i(sig_nb_i), .sig_bits_i(sig_bits_i), .samp_ready_i(samp_ready_i),
    .samp_valid_o(samp_valid_o), .samp_re_o(samp_re_o), .samp_im_o(samp_im_o),
    .samp_first_o(samp_first_o), .samp_last_o(samp_last_o),
    .sym_first_o(sym_first_o), .sym_last_o(sym_last_o), .ready_o(ready_o));
  sample_sink i_sink (.clk_sys_i(clk_sys_i), .stall_i(stall), .samp_ready_o(samp_ready_i));
  always @(posedge clk_sys_i)
    if (samp_valid_o && samp_ready_i && ce_i)
      got_q.push_back({samp_re_o, samp_im_o, samp_first_o, samp_last_o,
                       sym_first_o, sym_last_o});
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input int tol);
    int d;
    d = $signed(seen) - $signed(exp);
    num_checks++;
    if (^seen === 1'bx || (tol == 0 && seen !== exp) || d > tol || d < -tol) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(hang) print_verdict;
  function automatic bit cond(input int w, input int n);
    return w == 0 ? ready_o === 1'b1 : w == 1 ? samp_valid_o === 1'b1 : got_q.size() >= n;
  endfunction
  task automatic wait_for(input int w, input int n, input int lim);
    int i;
    for (i = 0; i < lim && !cond(w, n); i++)
      @(negedge clk_sys_i);
    if (!cond(w, n)) begin
      miscompares++;
      -> hang;
    end
  endtask
  // Reference samples 0..2 of symbol 0, unshifted
  task automatic build_expect(input logic [15:0] sd, input int q, input bit neg);
    logic [15:0] r;
    bit          p[0:748];
    real         c, a, w;
    longint      ph;
    int          k, t, m;
    r = sd;
    for (k = 0; k < 749; k++) begin
      p[k] = r[0];
      r = {r[15] ^ r[14] ^ r[1] ^ r[0], r[15:1]};
    end
    for (t = 0; t < 3; t++) begin
      er[t] = 0.0;
      ei[t] = 0.0;
    end
    for (k = 1; k <= 749; k++) begin
      m = 749 + k;
      ph = (longint'(q) * m * (m + 1)) % 2998;
      a = -3.14159265358979 * ph / 1499.0;
      c = (p[749 - k] ? -512.0 : 512.0) * (neg ? -1.0 : 1.0) / $sqrt(1498.0);
      for (t = 0; t < 3; t++) begin
        w = c * $cos(2.0 * 3.14159265358979 * k * t / 2048.0);
        er[t] += w * $cos(a);
        ei[t] += w * $sin(a);
      end
    end
  endtask
  task automatic run(input int ns, input logic [6:0] cnt, input bit hard);
    int          i;
    logic [35:0] g;
    logic [15:0] sd;
    wait_for(0, 0, 40000);
    for (i = 1; i < cnt; i++) begin
      sig_wr_i = 1'b1;
      sig_sym_i = 6'(i);
      sig_nb_i = 4'($unsigned($random(seed)) % 12);
      sig_bits_i = 11'($random(seed));
      @(negedge clk_sys_i);
    end
    sig_wr_i = 1'b0;
    sym_count_i = cnt;
    sd = pn_seed_i;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    check(ready_o, 16'h0000, 0);
    got_q.delete();
    if (hard) begin
      pn_seed_i = ~sd;
      start_i = 1'b1;
      @(negedge clk_sys_i);
      start_i = 1'b0;
      check(ready_o, 16'h0000, 0);
      wait_for(1, 0, 20000);
      ce_i = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      ce_i = 1'b1;
      repeat (1600) @(negedge clk_sys_i);
    end
    stall = 1'b0;
    wait_for(2, ns, 20000);
    build_expect(sd, zc_root_i, cnt <= 1);
    for (i = 0; i < ns; i++) begin
      g = got_q.pop_front();
      check(g[35:20], 16'($rtoi(er[i])), 8);
      check(g[19:4], 16'($rtoi(ei[i])), 8);
      check(g[3], 16'(i == 0), 0);
      check(g[2], 16'h0000, 0);
      check(g[1], 16'h0001, 0);
      check(g[0], 16'(cnt <= 1), 0);
    end
  endtask
  initial begin
    pn_seed_i = 16'($random(seed));
    zc_root_i = 11'(1 + $unsigned($random(seed)) % 1498);
    repeat (3) @(negedge clk_sys_i);
    check(ready_o, 16'h0000, 0);
    check(samp_valid_o, 16'h0000, 0);
    rst_n_i = 1'b1;
    run(3, 7'(2 + $unsigned($random(seed)) % 63), 1'b1);
    $display("test 1 done");
    rst_n_i = 1'b0;
    stall = 1'b1;
    pn_seed_i = ~pn_seed_i;
    zc_root_i = 11'h5DA;
    repeat (3) @(negedge clk_sys_i);
    check(samp_valid_o, 16'h0000, 0);
    rst_n_i = 1'b1;
    run(2, 7'h01, 1'b0);
    $display("test 2 done");
    print_verdict;
  end
endmodule // tb_bootstrap_symbol_gen
bind bootstrap_symbol_gen bootstrap_checker i_chk (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .ce_i(ce_i), .start_i(start_i), .samp_ready_i(samp_ready_i),
  .samp_valid_o(samp_valid_o), .samp_re_o(samp_re_o), .samp_im_o(samp_im_o),
  .samp_first_o(samp_first_o), .samp_last_o(samp_last_o), .sym_last_o(sym_last_o),
  .ready_o(ready_o));
`default_nettype wire
